/* File: core/lmd_pkg.sv */
package lmd_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CLEAR_CTRL_ADDR = 8'h34;
    localparam logic [7:0] OPEN_LOW_ADDR = 8'h35;
    localparam logic [7:0] OPEN_HIGH_ADDR = 8'h36;
    localparam logic [7:0] SHORT_LOW_ADDR = 8'h37;
    localparam logic [7:0] SHORT_HIGH_ADDR = 8'h38;
    localparam logic [7:0] THERM_PUMP_ADDR = 8'h39;
    localparam logic [7:0] IDENT_HEALTH_ADDR = 8'h3a;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CLR_SHORT_BIT = 0;
    localparam int CLR_OPEN_BIT = 1;
    localparam int LOW_REG_CHANNELS = 8;
    localparam int PUMP_FAULT_BIT = 7;
    localparam int THERM_CODE_LSB = 1;
    localparam int THERM_CODE_W = 6;
    localparam int THERM_FAULT_BIT = 0;
    localparam int OTW_FIRST_BIT = 7;
    localparam int OTW_SECOND_BIT = 6;
    localparam int POWER_GOOD_BIT = 5;
    localparam int LIMP_HOME_BIT = 4;
    localparam int IDENT_CODE_LSB = 1;
    localparam int IDENT_CODE_W = 3;
    localparam int IDENT_FAULT_BIT = 0;

    // ------------------------------------------------------------
    // Commands, reset values, counts
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_CLEAR_ALL = 8'h27;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int NUM_CHANNELS = 11;
    localparam int MAX_CHANNELS = 16;

endpackage

/* File: core/lmd_fault_bank.sv */
`timescale 1ns/1ps
module lmd_fault_bank #(
    parameter int WIDTH = 11
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [WIDTH-1:0] detect_i,
    input wire logic clear_i,
    output logic [WIDTH-1:0] flags_o
);

    logic [WIDTH-1:0] flags_reg;
    logic [WIDTH-1:0] flags_next;

    // ------------------------------------------------------------
    // Sticky flags
    // ------------------------------------------------------------
    // Set beats clear so a fault seen in the clearing cycle survives
    assign flags_next = detect_i | (flags_reg & ~{WIDTH{clear_i}});

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            flags_reg <= '0;
        else
            flags_reg <= flags_next;
    end

    assign flags_o = flags_reg;

endmodule // lmd_fault_bank

/* File: core/lmd_read_port.sv */
`timescale 1ns/1ps
module lmd_read_port (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic rd_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] open_low_i,
    input wire logic [7:0] open_high_i,
    input wire logic [7:0] short_low_i,
    input wire logic [7:0] short_high_i,
    input wire logic [7:0] therm_pump_i,
    input wire logic [7:0] ident_health_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output logic rerror_o
);
    import lmd_pkg::*;

    logic [7:0] rdata_reg;
    logic rvalid_reg;
    logic rerror_reg;
    logic [7:0] sel_data;
    logic sel_hit;

    // ------------------------------------------------------------
    // Read selection
    // ------------------------------------------------------------
    // Clear bits always read back as zero; the rest of 0x34 reads as zero too
    assign sel_hit = (addr_i == CLEAR_CTRL_ADDR) || (addr_i == OPEN_LOW_ADDR)
        || (addr_i == OPEN_HIGH_ADDR) || (addr_i == SHORT_LOW_ADDR)
        || (addr_i == SHORT_HIGH_ADDR) || (addr_i == THERM_PUMP_ADDR)
        || (addr_i == IDENT_HEALTH_ADDR);
    assign sel_data = (addr_i == OPEN_LOW_ADDR) ? open_low_i :
        (addr_i == OPEN_HIGH_ADDR) ? open_high_i :
        (addr_i == SHORT_LOW_ADDR) ? short_low_i :
        (addr_i == SHORT_HIGH_ADDR) ? short_high_i :
        (addr_i == THERM_PUMP_ADDR) ? therm_pump_i :
        (addr_i == IDENT_HEALTH_ADDR) ? ident_health_i : REG_RESET;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rdata_reg <= REG_RESET;
            rvalid_reg <= 1'b0;
            rerror_reg <= 1'b0;
        end
        else
        begin
            rdata_reg <= rd_i ? sel_data : rdata_reg;
            rvalid_reg <= rd_i;
            rerror_reg <= rd_i && !sel_hit;
        end
    end

    assign rdata_o = rdata_reg;
    assign rvalid_o = rvalid_reg;
    assign rerror_o = rerror_reg;

endmodule // lmd_read_port

/* File: core/lmd_diag_status.sv */
`timescale 1ns/1ps
module lmd_diag_status #(
    parameter int NUM_CH = lmd_pkg::NUM_CHANNELS
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Register access from the command link
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic reg_rerror_o,
    // Command link
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    // Analog detectors, already in this clock domain
    input wire logic [NUM_CH-1:0] open_detect_i,
    input wire logic [NUM_CH-1:0] short_detect_i,
    input wire logic pump_cap_fault_i,
    input wire logic [5:0] thermistor_code_i,
    input wire logic thermistor_pin_fault_i,
    input wire logic overtemp_warn_first_i,
    input wire logic overtemp_warn_second_i,
    input wire logic power_good_i,
    input wire logic limp_home_flag_i,
    input wire logic [2:0] ident_code_i,
    input wire logic ident_pin_fault_i,
    // Switch and driver control
    output logic [NUM_CH-1:0] bypass_close_o,
    output logic channel_restart_o,
    output logic gate_drive_enable_o,
    output logic dimming_enable_o,
    output logic power_good_o
);
    import lmd_pkg::*;

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    // High register holds channels 9 up; more than 16 would need a third register
    generate
        if (NUM_CH <= LOW_REG_CHANNELS || NUM_CH > MAX_CHANNELS)
        begin : g_bad_width
            $error("NUM_CH must lie between 9 and 16");
        end
    endgenerate

    // ------------------------------------------------------------
    // Clear decoding
    // ------------------------------------------------------------
    logic clear_write;
    logic clear_all_cmd;
    logic clear_open;
    logic clear_short;

    assign clear_write = reg_wr_i && (reg_addr_i == CLEAR_CTRL_ADDR);
    assign clear_all_cmd = cmd_valid_i && (cmd_code_i == CMD_CLEAR_ALL);
    assign clear_open = (clear_write && reg_wdata_i[CLR_OPEN_BIT]) || clear_all_cmd;
    assign clear_short = (clear_write && reg_wdata_i[CLR_SHORT_BIT]) || clear_all_cmd;

    // ------------------------------------------------------------
    // Sticky fault flags
    // ------------------------------------------------------------
    logic [NUM_CH-1:0] open_flags;
    logic [NUM_CH-1:0] short_flags;

    // Detection only happens while the device runs, i.e. out of reset
    lmd_fault_bank #(
        .WIDTH(NUM_CH)
    ) u_open_bank (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .detect_i(open_detect_i),
        .clear_i(clear_open),
        .flags_o(open_flags)
    );

    lmd_fault_bank #(
        .WIDTH(NUM_CH)
    ) u_short_bank (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .detect_i(short_detect_i),
        .clear_i(clear_short),
        .flags_o(short_flags)
    );

    // ------------------------------------------------------------
    // Register images
    // ------------------------------------------------------------
    logic [MAX_CHANNELS-1:0] open_wide;
    logic [MAX_CHANNELS-1:0] short_wide;
    logic [7:0] open_low;
    logic [7:0] open_high;
    logic [7:0] short_low;
    logic [7:0] short_high;
    logic [7:0] therm_pump;
    logic [7:0] ident_health;

    // Unused high bits read as zero
    // Cast rather than replicate, so NUM_CH of 16 needs no empty replication
    assign open_wide = MAX_CHANNELS'(open_flags);
    assign short_wide = MAX_CHANNELS'(short_flags);
    assign open_low = open_wide[7:0];
    assign open_high = open_wide[15:8];
    assign short_low = short_wide[7:0];
    assign short_high = short_wide[15:8];

    // Live status: writes to 0x39 have nothing to store, the analog side owns it
    assign therm_pump = {pump_cap_fault_i,
        thermistor_code_i,
        thermistor_pin_fault_i};
    assign ident_health = {overtemp_warn_first_i, overtemp_warn_second_i,
        power_good_i,
        limp_home_flag_i,
        ident_code_i, ident_pin_fault_i};

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    lmd_read_port u_read (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .rd_i(reg_rd_i),
        .addr_i(reg_addr_i),
        .open_low_i(open_low),
        .open_high_i(open_high),
        .short_low_i(short_low),
        .short_high_i(short_high),
        .therm_pump_i(therm_pump),
        .ident_health_i(ident_health),
        .rdata_o(reg_rdata_o),
        .rvalid_o(reg_rvalid_o),
        .rerror_o(reg_rerror_o)
    );

    // ------------------------------------------------------------
    // Switch and driver control
    // ------------------------------------------------------------
    logic restart_reg;
    logic gate_en_reg;
    logic pgood_reg;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            restart_reg <= 1'b0;
            gate_en_reg <= 1'b0;
            pgood_reg <= 1'b0;
        end
        else
        begin
            restart_reg <= clear_open || clear_short;
            gate_en_reg <= !pump_cap_fault_i;
            pgood_reg <= power_good_i;
        end
    end

    // Flag is a flop, so the bypass holds until the host clears the open
    assign bypass_close_o = open_flags;
    assign channel_restart_o = restart_reg;
    assign gate_drive_enable_o = gate_en_reg;
    assign dimming_enable_o = gate_en_reg;
    assign power_good_o = pgood_reg;

endmodule // lmd_diag_status

/* File: verif/lmd_diag_status_chk.sv */
`timescale 1ns/1ps
module lmd_diag_status_chk #(
    parameter int NUM_CH = 11
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rvalid_o,
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [NUM_CH-1:0] open_detect_i,
    input wire logic pump_cap_fault_i,
    input wire logic [NUM_CH-1:0] bypass_close_o,
    input wire logic channel_restart_o,
    input wire logic gate_drive_enable_o
);
    import lmd_pkg::*;
    wire logic clr_cmd = cmd_valid_i && cmd_code_i == CMD_CLEAR_ALL;
    wire logic clr_reg = reg_wr_i && reg_addr_i == CLEAR_CTRL_ADDR;
    wire logic clr_open = clr_cmd || (clr_reg && reg_wdata_i[CLR_OPEN_BIT]);
    wire logic clr_any = clr_open || (clr_reg && reg_wdata_i[CLR_SHORT_BIT]);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    a_read_answer_next: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read not answered");
    a_no_stray_valid: assert property (!reg_rd_i |=> !reg_rvalid_o)
        else $error("answer without read");
    a_open_sets_flag: assert property ((open_detect_i != '0) |=>
        (bypass_close_o & $past(open_detect_i)) == $past(open_detect_i))
        else $error("open fault not latched");
    a_flag_stays_latched: assert property (!clr_open |=>
        (bypass_close_o & $past(bypass_close_o)) == $past(bypass_close_o))
        else $error("open flag dropped");
    a_reg_clear_open: assert property ((clr_reg && reg_wdata_i[CLR_OPEN_BIT]) |=>
        bypass_close_o == $past(open_detect_i))
        else $error("register clear missed");
    a_cmd_clear_all: assert property (clr_cmd |=> bypass_close_o == $past(open_detect_i))
        else $error("command clear missed");
    a_restart_after_clear: assert property (clr_any |=> channel_restart_o)
        else $error("no restart pulse");
    a_gate_follows_pump: assert property (1'b1 |=> gate_drive_enable_o == !$past(pump_cap_fault_i))
        else $error("gate drive wrong");
    c_read: cover property (reg_rd_i ##1 reg_rvalid_o);
    c_cmd_clear: cover property (clr_cmd);
    c_open_then_clear: cover property ((open_detect_i != '0) ##[1:20] clr_open);
endmodule // lmd_diag_status_chk
bind lmd_diag_status lmd_diag_status_chk #(.NUM_CH(NUM_CH)) i_chk (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rvalid_o(reg_rvalid_o), .cmd_valid_i(cmd_valid_i),
    .cmd_code_i(cmd_code_i), .open_detect_i(open_detect_i), .pump_cap_fault_i(pump_cap_fault_i),
    .bypass_close_o(bypass_close_o), .channel_restart_o(channel_restart_o),
    .gate_drive_enable_o(gate_drive_enable_o));

/* File: verif/lmd_host_model.sv */
`timescale 1ns/1ps
module lmd_host_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i,
    input wire logic rerror_i,
    input wire logic power_good_i,
    output logic wr_o = 1'b0,
    output logic rd_o = 1'b0,
    output logic [7:0] addr_o = 8'h00,
    output logic [7:0] wdata_o = 8'h00,
    output logic cmd_valid_o = 1'b0,
    output logic [7:0] cmd_code_o = 8'h00
);
    // Released lines show the inverse, so stale values never look valid
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q, output logic [1:0] f);
        @(posedge clk_i);
        wr_o <= w;
        rd_o <= !w;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
        // Answer is taken at the edge that samples the valid pulse
        @(posedge clk_i);
        q = rdata_i;
        f = {rvalid_i, rerror_i};
    endtask
    task automatic command(input logic [7:0] c);
        @(posedge clk_i);
        cmd_valid_o <= 1'b1;
        cmd_code_o <= c;
        @(posedge clk_i);
        cmd_valid_o <= 1'b0;
        cmd_code_o <= ~c;
    endtask
    task automatic wait_power_good(output logic ok);
        ok = 1'b0;
        for (int n = 0; n < 50 && !ok; n++)
        begin
            @(posedge clk_i);
            ok = power_good_i;
        end
    endtask
endmodule // lmd_host_model

/* File: verif/led_matrix_diagnostic_status_tb.sv */
`timescale 1ns/1ps
module led_matrix_diagnostic_status_tb;
    import lmd_pkg::*;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [10:0] open_detect_i = '0;
    logic [10:0] short_detect_i = '0;
    logic [7:0] therm_img = 8'h00;
    logic [7:0] ident_img = 8'h00;
    logic [7:0] imgs [4] = '{8'hf3, 8'h0e, 8'haa, 8'h55};
    logic [7:0] rdata, wd, q;
    logic [1:0] f;
    logic [10:0] bypass;
    logic wr, rd_s, cv, rvalid, rerror, restart, gate, dim, pgood, ok;
    logic [7:0] addr, code;
    int err_total = 0;
    int tests_run = 0;
    always #5 clk_i = ~clk_i;
    lmd_host_model i_host (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .rerror_i(rerror),
        .power_good_i(pgood), .wr_o(wr), .rd_o(rd_s), .addr_o(addr), .wdata_o(wd),
        .cmd_valid_o(cv), .cmd_code_o(code));
    lmd_diag_status i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_wr_i(wr), .reg_rd_i(rd_s),
        .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .reg_rerror_o(rerror), .cmd_valid_i(cv), .cmd_code_i(code),
        .open_detect_i(open_detect_i), .short_detect_i(short_detect_i),
        .pump_cap_fault_i(therm_img[7]), .thermistor_code_i(therm_img[6:1]),
        .thermistor_pin_fault_i(therm_img[0]), .overtemp_warn_first_i(ident_img[7]),
        .overtemp_warn_second_i(ident_img[6]), .power_good_i(ident_img[5]),
        .limp_home_flag_i(ident_img[4]), .ident_code_i(ident_img[3:1]),
        .ident_pin_fault_i(ident_img[0]), .bypass_close_o(bypass), .channel_restart_o(restart),
        .gate_drive_enable_o(gate), .dimming_enable_o(dim), .power_good_o(pgood));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        i_host.access(1'b0, a, 8'h00, q, f);
        chk(q, exp);
        chk({6'h00, f}, {7'h01, a < CLEAR_CTRL_ADDR || a > IDENT_HEALTH_ADDR});
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        i_host.access(1'b1, a, d, q, f);
    endtask
    task automatic pulse(input logic [10:0] o, input logic [10:0] s);
        @(posedge clk_i);
        open_detect_i <= o;
        short_detect_i <= s;
        @(posedge clk_i);
        open_detect_i <= '0;
        short_detect_i <= '0;
    endtask
    task automatic conclude();
        $display("tests_run=%0d err_total=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        for (int a = 'h35; a <= 'h3a; a++)
            rd(8'(a), REG_RESET);
        $display("test reset_values done");
        pulse(11'h101, 11'h480);
        rd(OPEN_LOW_ADDR, 8'h01);
        rd(OPEN_HIGH_ADDR, 8'h01);
        rd(SHORT_LOW_ADDR, 8'h80);
        rd(SHORT_HIGH_ADDR, 8'h04);
        chk(bypass[7:0], 8'h01);
        chk({5'h00, bypass[10:8]}, 8'h01);
        wr_reg(OPEN_LOW_ADDR, 8'hff);
        rd(OPEN_LOW_ADDR, 8'h01);
        rd(8'h40, 8'h00);
        $display("test latch done");
        wr_reg(CLEAR_CTRL_ADDR, 8'h02);
        chk({7'h00, restart}, 8'h01);
        rd(OPEN_LOW_ADDR, 8'h00);
        rd(SHORT_LOW_ADDR, 8'h80);
        rd(CLEAR_CTRL_ADDR, 8'h00);
        wr_reg(CLEAR_CTRL_ADDR, 8'h01);
        rd(SHORT_HIGH_ADDR, 8'h00);
        $display("test register_clear done");
        pulse(11'h7ff, 11'h7ff);
        i_host.command(8'h26);
        rd(OPEN_HIGH_ADDR, 8'h07);
        i_host.command(CMD_CLEAR_ALL);
        rd(OPEN_HIGH_ADDR, 8'h00);
        rd(SHORT_LOW_ADDR, 8'h00);
        $display("test command_clear done");
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk_i);
            therm_img <= imgs[k];
            ident_img <= imgs[k + 2];
            wr_reg(THERM_PUMP_ADDR, 8'h00);
            rd(THERM_PUMP_ADDR, imgs[k]);
            chk({7'h00, q[0]}, {7'h00, imgs[k][0]});
            rd(IDENT_HEALTH_ADDR, imgs[k + 2]);
            chk({7'h00, q[5]}, {7'h00, imgs[k + 2][5]});
            chk({7'h00, q[4]}, {7'h00, imgs[k + 2][4]});
            chk({4'h0, q[3:0]}, {4'h0, imgs[k + 2][3:0]});
            chk({5'h00, gate, dim, pgood}, {5'h00, {2{~imgs[k][7]}}, imgs[k + 2][5]});
        end
        ident_img <= 8'h20;
        i_host.wait_power_good(ok);
        chk({7'h00, ok}, 8'h01);
        $display("test status_images done");
        conclude();
    end
    initial
    begin
        #50000;
        err_total++;
        $display("[FAIL] %0t ns: watchdog expired", $time);
        conclude();
    end
endmodule // led_matrix_diagnostic_status_tb
